// ---- src/lmscg_pkg.sv ----
// constants, field layouts and types shared by the scan and current-gain block
package lmscg_pkg;
	localparam int N_LINES = 6;
	localparam int N_SINKS = 18;
	localparam int N_DOTS = 108;
	localparam int CNT_W = 12;

	// timing in picoseconds, clock period included
	localparam int CLK_PS = 10000;
	localparam int T_PWM_FAST_PS = 8000000;
	localparam int T_PWM_SLOW_PS = 16000000;
	localparam int T_BLK_LONG_PS = 1000000;
	localparam int T_BLK_SHORT_PS = 500000;
	localparam int T_PHASE_PS = 125000;
	localparam int T_CSD_FAST_PS = 31250;
	localparam int T_CSD_SLOW_PS = 62500;
	localparam logic [CNT_W-1:0] CYC_PWM_FAST = CNT_W'(T_PWM_FAST_PS / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_PWM_SLOW = CNT_W'(T_PWM_SLOW_PS / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_BLK_LONG = CNT_W'(T_BLK_LONG_PS / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_BLK_SHORT = CNT_W'(T_BLK_SHORT_PS / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_PHASE = CNT_W'((T_PHASE_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_CSD_FAST = CNT_W'((T_CSD_FAST_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CYC_CSD_SLOW = CNT_W'((T_CSD_SLOW_PS + CLK_PS - 1) / CLK_PS);

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PEAK = 8'h04;
	localparam logic [7:0] ADDR_DEGHOST = 8'h08;
	localparam logic [7:0] ADDR_COMP = 8'h0C;
	localparam logic [7:0] ADDR_COLOR = 8'h10;
	localparam logic [7:0] ADDR_DOT_IDX = 8'h14;
	localparam logic [7:0] ADDR_DOT_DATA = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_SINK_UA = 8'h20;
	localparam logic [7:0] ADDR_AVG_UA = 8'h24;

	// control register fields
	localparam int CTRL_CHIP_EN = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_PWM_SLOW = 3;
	localparam int CTRL_BLK_SHORT = 4;
	localparam int CTRL_PHASE = 5;
	localparam int CTRL_CS_SHIFT = 6;
	localparam int CTRL_LINES_LSB = 8;
	// byte lanes of the three-field registers and of the deghost register
	localparam int FIELD_STRIDE = 8;
	localparam int DG_DOWN_LSB = 8;
	localparam int DG_APPLIED_LSB = 16;

	localparam logic [1:0] MODE_INSTANT = 2'h1;
	localparam logic [1:0] RST_MODE = 2'h1;
	localparam logic [2:0] RST_PEAK = 3'h3;
	localparam logic [2:0] PEAK_MAX = 3'h6;
	localparam logic [6:0] RST_COLOR = 7'h40;
	localparam logic [7:0] RST_DOT = 8'h80;
	localparam logic [2:0] RST_LAST_LINE = 3'h5;

	typedef struct packed {
		logic pwm_slow;
		logic blk_short;
		logic phase_en;
		logic cs_shift;
		logic [2:0] last_line;
	} lmscg_timing_s;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} lmscg_bus_e;
endpackage : lmscg_pkg

// ---- src/lmscg_scan_seq.sv ----
// slot counter and scan line pointer
`timescale 1ns/1ps
module lmscg_scan_seq (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_run,
	input wire logic [lmscg_pkg::CNT_W-1:0] i_slot_len,
	input wire logic [2:0] i_last_line,
	output logic [lmscg_pkg::CNT_W-1:0] o_cnt,
	output logic [2:0] o_line
);
	logic slot_end;

	assign slot_end = (o_cnt >= i_slot_len - lmscg_pkg::CNT_W'(1));

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || !i_run) begin
			o_cnt <= '0;
		end else if (slot_end) begin
			o_cnt <= '0;
		end else begin
			o_cnt <= o_cnt + lmscg_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || !i_run) begin
			o_line <= 3'h0;
		end else if (slot_end) begin
			o_line <= (o_line >= i_last_line) ? 3'h0 : o_line + 3'h1;
		end
	end
endmodule : lmscg_scan_seq

// ---- src/lmscg_gain_calc.sv ----
// sink and average current of one dot in microamps
`timescale 1ns/1ps
module lmscg_gain_calc (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [2:0] i_peak_code,
	input wire logic [6:0] i_color_code,
	input wire logic [7:0] i_dot_code,
	input wire logic [2:0] i_last_line,
	output logic [16:0] o_sink_ua,
	output logic [16:0] o_avg_ua
);
	logic [33:0] prod;
	logic [16:0] sink_d;

	function automatic logic [16:0] peak_ua(input logic [2:0] code);
		unique case (code)
			3'h0: peak_ua = 17'd7500;
			3'h1: peak_ua = 17'd12500;
			3'h2: peak_ua = 17'd25000;
			3'h3: peak_ua = 17'd37500;
			3'h4: peak_ua = 17'd50000;
			3'h5: peak_ua = 17'd75000;
			3'h6: peak_ua = 17'd100000;
			default: peak_ua = 17'd0;
		endcase
	endfunction : peak_ua

	// peak times color over 127 times dot over 255
	assign prod = 34'(peak_ua(i_peak_code)) * 34'(i_color_code) * 34'(i_dot_code);
	assign sink_d = 17'(prod / 34'd32385);

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_sink_ua <= 17'h0;
			o_avg_ua <= 17'h0;
		end else begin
			o_sink_ua <= sink_d;
			o_avg_ua <= 17'(sink_d / (17'(i_last_line) + 17'h1));
		end
	end
endmodule : lmscg_gain_calc

// ---- src/lmscg_top.sv ----
// scan sequencer and current-gain control with an avalon-mm register slave
`timescale 1ns/1ps
module lmscg_top #(
	parameter int DG_W = 2,
	parameter int COMP_W = 2
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [lmscg_pkg::N_LINES-1:0] o_scan_line_switch_output,
	output logic [lmscg_pkg::N_SINKS-1:0] o_current_sink_output,
	output logic o_up_deghost_active,
	output logic [DG_W-1:0] o_up_deghost_level,
	output logic o_down_deghost_active,
	output logic [DG_W-1:0] o_down_deghost_level,
	output logic [lmscg_pkg::N_SINKS*COMP_W-1:0] o_sink_comp_level,
	output logic [2:0] o_peak_current_code
);
	localparam int NL = lmscg_pkg::N_LINES;
	localparam int NS = lmscg_pkg::N_SINKS;
	localparam int CW = lmscg_pkg::CNT_W;
	localparam int FS = lmscg_pkg::FIELD_STRIDE;

	if (DG_W < 1 || DG_W > FS || COMP_W < 1 || COMP_W > FS) begin : g_bad_width
		$error("deghost and compensation widths must be 1 to 8");
	end

	lmscg_pkg::lmscg_bus_e bus_q;
	logic [31:0] rdata_d;
	logic wr_stb;
	logic [31:0] wdata;

	logic chip_en_q;
	logic chip_en_prev_q;
	logic [1:0] mode_q;
	lmscg_pkg::lmscg_timing_s tim_q;
	logic [2:0] peak_pend_q;
	logic [2:0] peak_app_q;
	logic [DG_W-1:0] up_pend_q;
	logic [DG_W-1:0] down_pend_q;
	logic [DG_W-1:0] up_app_q;
	logic [DG_W-1:0] down_app_q;
	logic [COMP_W-1:0] comp_q [3];
	logic [6:0] color_q [3];
	logic [7:0] dot_q [lmscg_pkg::N_DOTS];
	logic [6:0] dot_idx_q;
	logic gate_accept;
	logic apply_now;

	logic [CW-1:0] cnt;
	logic [2:0] line;
	logic [CW-1:0] pwm_cyc;
	logic [CW-1:0] blk_cyc;
	logic [CW-1:0] ph_cyc;
	logic [CW-1:0] csd_cyc;
	logic [CW-1:0] slot_len;
	logic [16:0] sink_ua;
	logic [16:0] avg_ua;
	logic in_blank;
	logic [NS-1:0] sink_d;

	// byte-lane merge of a write onto the current value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	function automatic logic [1:0] group_of(input int sink);
		group_of = 2'(sink % 3);
	endfunction : group_of

	function automatic logic [31:0] pack3(input logic [6:0] a, input logic [6:0] b,
			input logic [6:0] c);
		pack3 = {8'h0, 1'b0, c, 1'b0, b, 1'b0, a};
	endfunction : pack3

	// avalon slave: one wait cycle, effect at the edge that sees waitrequest low
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			bus_q <= lmscg_pkg::BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0;
		end else begin
			unique case (bus_q)
				lmscg_pkg::BUS_IDLE: begin
					if (i_avs_read || i_avs_write) begin
						bus_q <= lmscg_pkg::BUS_ACK;
						o_avs_waitrequest <= 1'b0;
						o_avs_readdata <= i_avs_read ? rdata_d : 32'h0;
					end
				end
				lmscg_pkg::BUS_ACK: begin
					bus_q <= lmscg_pkg::BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_q <= lmscg_pkg::BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	assign wr_stb = (bus_q == lmscg_pkg::BUS_ACK) && i_avs_write;

	always_comb begin
		rdata_d = 32'h0;
		unique case (i_avs_address)
			lmscg_pkg::ADDR_CTRL: begin
				rdata_d[lmscg_pkg::CTRL_CHIP_EN] = chip_en_q;
				rdata_d[lmscg_pkg::CTRL_MODE_LSB +: 2] = mode_q;
				rdata_d[lmscg_pkg::CTRL_PWM_SLOW] = tim_q.pwm_slow;
				rdata_d[lmscg_pkg::CTRL_BLK_SHORT] = tim_q.blk_short;
				rdata_d[lmscg_pkg::CTRL_PHASE] = tim_q.phase_en;
				rdata_d[lmscg_pkg::CTRL_CS_SHIFT] = tim_q.cs_shift;
				rdata_d[lmscg_pkg::CTRL_LINES_LSB +: 3] = tim_q.last_line;
			end
			lmscg_pkg::ADDR_PEAK: rdata_d = {21'h0, peak_app_q, 5'h0, peak_pend_q};
			lmscg_pkg::ADDR_DEGHOST: begin
				rdata_d[0 +: DG_W] = up_pend_q;
				rdata_d[lmscg_pkg::DG_DOWN_LSB +: DG_W] = down_pend_q;
				rdata_d[lmscg_pkg::DG_APPLIED_LSB +: DG_W] = up_app_q;
				rdata_d[lmscg_pkg::DG_APPLIED_LSB + FS +: DG_W] = down_app_q;
			end
			lmscg_pkg::ADDR_COMP: begin
				for (int g = 0; g < 3; g++) begin
					rdata_d[g*FS +: COMP_W] = comp_q[g];
				end
			end
			lmscg_pkg::ADDR_COLOR: rdata_d = pack3(color_q[0], color_q[1], color_q[2]);
			lmscg_pkg::ADDR_DOT_IDX: rdata_d = {25'h0, dot_idx_q};
			lmscg_pkg::ADDR_DOT_DATA: rdata_d = {24'h0, dot_q[dot_idx_q]};
			lmscg_pkg::ADDR_STATUS: rdata_d = {27'h0, in_blank, chip_en_q, line};
			lmscg_pkg::ADDR_SINK_UA: rdata_d = {15'h0, sink_ua};
			lmscg_pkg::ADDR_AVG_UA: rdata_d = {15'h0, avg_ua};
			default: rdata_d = 32'h0;
		endcase
	end

	always_comb begin
		wdata = 32'h0;
		unique case (i_avs_address)
			lmscg_pkg::ADDR_COLOR: wdata = pack3(color_q[0], color_q[1], color_q[2]);
			lmscg_pkg::ADDR_DOT_DATA: wdata = {24'h0, dot_q[dot_idx_q]};
			default: wdata = rdata_d;
		endcase
		wdata = merge(wdata, i_avs_writedata, i_avs_byteenable);
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			chip_en_q <= 1'b0;
			mode_q <= lmscg_pkg::RST_MODE;
			tim_q <= '{pwm_slow: 1'b0, blk_short: 1'b0, phase_en: 1'b0, cs_shift: 1'b0,
				last_line: lmscg_pkg::RST_LAST_LINE};
		end else if (wr_stb && i_avs_address == lmscg_pkg::ADDR_CTRL) begin
			chip_en_q <= wdata[lmscg_pkg::CTRL_CHIP_EN];
			mode_q <= wdata[lmscg_pkg::CTRL_MODE_LSB +: 2];
			tim_q.pwm_slow <= wdata[lmscg_pkg::CTRL_PWM_SLOW];
			tim_q.blk_short <= wdata[lmscg_pkg::CTRL_BLK_SHORT];
			tim_q.phase_en <= wdata[lmscg_pkg::CTRL_PHASE];
			tim_q.cs_shift <= wdata[lmscg_pkg::CTRL_CS_SHIFT];
			// line counts above six clamp to six
			tim_q.last_line <= (wdata[lmscg_pkg::CTRL_LINES_LSB +: 3] > 3'(NL - 1)) ?
				3'(NL - 1) : wdata[lmscg_pkg::CTRL_LINES_LSB +: 3];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			chip_en_prev_q <= 1'b0;
		end else begin
			chip_en_prev_q <= chip_en_q;
		end
	end

	// frame modes take the value only while the chip is off
	assign gate_accept = (mode_q == lmscg_pkg::MODE_INSTANT) || !chip_en_q;
	// instant mode applies every cycle; frame modes on chip-enable rise
	assign apply_now = (mode_q == lmscg_pkg::MODE_INSTANT) || (chip_en_q && !chip_en_prev_q);

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			peak_pend_q <= lmscg_pkg::RST_PEAK;
			up_pend_q <= '0;
			down_pend_q <= '0;
		end else if (wr_stb && gate_accept) begin
			if (i_avs_address == lmscg_pkg::ADDR_PEAK) begin
				// unused code seven is refused
				if (wdata[2:0] <= lmscg_pkg::PEAK_MAX) begin
					peak_pend_q <= wdata[2:0];
				end
			end
			if (i_avs_address == lmscg_pkg::ADDR_DEGHOST) begin
				up_pend_q <= wdata[0 +: DG_W];
				down_pend_q <= wdata[lmscg_pkg::DG_DOWN_LSB +: DG_W];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			peak_app_q <= lmscg_pkg::RST_PEAK;
			up_app_q <= '0;
			down_app_q <= '0;
		end else if (apply_now) begin
			// applied copy follows the accepted one
			peak_app_q <= peak_pend_q;
			up_app_q <= up_pend_q;
			down_app_q <= down_pend_q;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			for (int g = 0; g < 3; g++) begin
				color_q[g] <= lmscg_pkg::RST_COLOR;
				comp_q[g] <= '0;
			end
		end else if (wr_stb) begin
			for (int g = 0; g < 3; g++) begin
				if (i_avs_address == lmscg_pkg::ADDR_COLOR) begin
					color_q[g] <= wdata[g*FS +: 7];
				end
				if (i_avs_address == lmscg_pkg::ADDR_COMP) begin
					comp_q[g] <= wdata[g*FS +: COMP_W];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			dot_idx_q <= 7'h0;
			for (int d = 0; d < lmscg_pkg::N_DOTS; d++) begin
				dot_q[d] <= lmscg_pkg::RST_DOT;
			end
		end else if (wr_stb) begin
			if (i_avs_address == lmscg_pkg::ADDR_DOT_IDX &&
					wdata[6:0] < 7'(lmscg_pkg::N_DOTS)) begin
				dot_idx_q <= wdata[6:0];
			end
			if (i_avs_address == lmscg_pkg::ADDR_DOT_DATA) begin
				dot_q[dot_idx_q] <= wdata[7:0];
			end
		end
	end

	assign pwm_cyc = tim_q.pwm_slow ? lmscg_pkg::CYC_PWM_SLOW : lmscg_pkg::CYC_PWM_FAST;
	assign blk_cyc = tim_q.blk_short ? lmscg_pkg::CYC_BLK_SHORT : lmscg_pkg::CYC_BLK_LONG;
	assign ph_cyc = tim_q.phase_en ? lmscg_pkg::CYC_PHASE : '0;
	// one internal clock at the selected rate
	assign csd_cyc = !tim_q.cs_shift ? '0 :
		(tim_q.pwm_slow ? lmscg_pkg::CYC_CSD_SLOW : lmscg_pkg::CYC_CSD_FAST);
	assign slot_len = pwm_cyc + blk_cyc + (ph_cyc << 1);

	lmscg_scan_seq u_seq (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_run(chip_en_q),
		.i_slot_len(slot_len),
		.i_last_line(tim_q.last_line),
		.o_cnt(cnt),
		.o_line(line)
	);

	// the dot at the index register sits on its own sink and line
	lmscg_gain_calc u_gain (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_peak_code(peak_app_q),
		.i_color_code(color_q[group_of(int'(dot_idx_q) % NS)]),
		.i_dot_code(dot_q[dot_idx_q]),
		.i_last_line(tim_q.last_line),
		.o_sink_ua(sink_ua),
		.o_avg_ua(avg_ua)
	);

	assign in_blank = chip_en_q && (cnt < blk_cyc);

	// with phase_en set, phases are staggered so sinks do not all switch on in the same cycle
	always_comb begin
		sink_d = '0;
		for (int s = 0; s < NS; s++) begin
			sink_d[s] = chip_en_q &&
				(cnt >= blk_cyc + CW'(group_of(s)) * ph_cyc + csd_cyc) &&
				(cnt < blk_cyc + CW'(group_of(s)) * ph_cyc + pwm_cyc);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_scan_line_switch_output <= '0;
			o_current_sink_output <= '0;
		end else begin
			for (int l = 0; l < NL; l++) begin
				// one line on outside the blank
				o_scan_line_switch_output[l] <= chip_en_q && !in_blank && (line == 3'(l));
			end
			o_current_sink_output <= sink_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_up_deghost_active <= 1'b0;
			o_down_deghost_active <= 1'b0;
			o_up_deghost_level <= '0;
			o_down_deghost_level <= '0;
			o_peak_current_code <= lmscg_pkg::RST_PEAK;
		end else begin
			o_up_deghost_active <= in_blank;
			o_up_deghost_level <= up_app_q;
			o_down_deghost_active <= in_blank;
			o_down_deghost_level <= down_app_q;
			o_peak_current_code <= peak_app_q;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_sink_comp_level <= '0;
		end else begin
			for (int s = 0; s < NS; s++) begin
				o_sink_comp_level[s*COMP_W +: COMP_W] <= comp_q[group_of(s)];
			end
		end
	end
endmodule : lmscg_top

// ---- verif/lmscg_top_sva.sv ----
// port-level assertions for the scan and current-gain block
`timescale 1ns/1ps
module lmscg_top_sva #(
	parameter int DG_W = 2,
	parameter int COMP_W = 2
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic o_avs_waitrequest,
	input wire logic [lmscg_pkg::N_LINES-1:0] o_scan_line_switch_output,
	input wire logic [lmscg_pkg::N_SINKS-1:0] o_current_sink_output,
	input wire logic o_up_deghost_active,
	input wire logic [DG_W-1:0] o_up_deghost_level,
	input wire logic o_down_deghost_active,
	input wire logic [DG_W-1:0] o_down_deghost_level,
	input wire logic [lmscg_pkg::N_SINKS*COMP_W-1:0] o_sink_comp_level,
	input wire logic [2:0] o_peak_current_code
);
	logic chip_q;
	logic [1:0] mode_q;
	logic [2:0] wcode_q;
	logic [5:0] last_q;
	logic wr_done;
	assign wr_done = i_avs_write && !o_avs_waitrequest;
	// shadow of what the bus wrote, so checks need no internal state
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			chip_q <= 1'b0;
			mode_q <= lmscg_pkg::RST_MODE;
		end else if (wr_done && i_avs_address == lmscg_pkg::ADDR_CTRL) begin
			chip_q <= i_avs_writedata[lmscg_pkg::CTRL_CHIP_EN];
			mode_q <= i_avs_writedata[lmscg_pkg::CTRL_MODE_LSB+:2];
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (wr_done) begin
			wcode_q <= i_avs_writedata[2:0];
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			last_q <= 6'h0;
		end else if (|o_scan_line_switch_output) begin
			last_q <= o_scan_line_switch_output;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	chk_line_onehot: assert property ($onehot0(o_scan_line_switch_output))
		else $error("more than one scan line on");
	chk_line_next: assert property ($rose(|o_scan_line_switch_output) && |last_q |->
		o_scan_line_switch_output == {last_q[4:0], 1'b0} || o_scan_line_switch_output == 6'h01)
		else $error("scan line out of order");
	chk_blank_dark: assert property (o_up_deghost_active |->
		o_scan_line_switch_output == '0 && o_current_sink_output == '0)
		else $error("line or sink on during blank");
	chk_blank_pair: assert property (o_down_deghost_active == o_up_deghost_active)
		else $error("precharge and clamp disagree");
	chk_blank_span: assert property ($rose(o_up_deghost_active) |->
		o_up_deghost_active[*8])
		else $error("blank interval too short");
	chk_comp_groups: assert property (
		o_sink_comp_level[lmscg_pkg::N_SINKS*COMP_W-1:3*COMP_W] ==
		{(lmscg_pkg::N_SINKS/3-1){o_sink_comp_level[3*COMP_W-1:0]}})
		else $error("compensation not grouped by sink modulo three");
	chk_peak_legal: assert property (o_peak_current_code <= lmscg_pkg::PEAK_MAX)
		else $error("peak code outside table");
	chk_peak_reset: assert property ($rose(i_rstn) |->
		o_peak_current_code == lmscg_pkg::RST_PEAK)
		else $error("peak code not at default after reset");
	chk_peak_instant: assert property (
		wr_done && i_avs_address == lmscg_pkg::ADDR_PEAK &&
		mode_q == lmscg_pkg::MODE_INSTANT && i_avs_writedata[2:0] <= lmscg_pkg::PEAK_MAX |->
		##[1:3] o_peak_current_code == wcode_q)
		else $error("instant peak write not applied");
	chk_frame_hold: assert property (mode_q != lmscg_pkg::MODE_INSTANT && chip_q &&
		$past(chip_q, 3) |-> $stable({o_peak_current_code, o_up_deghost_level, o_down_deghost_level}))
		else $error("applied setting changed while chip on");
	cover property ($rose(o_scan_line_switch_output[5]));
	cover property ($rose(o_up_deghost_active));
	cover property ($changed(o_peak_current_code));
endmodule : lmscg_top_sva

bind lmscg_top lmscg_top_sva #(.DG_W(DG_W), .COMP_W(COMP_W)) u_sva (
	.i_core_clk(i_core_clk),
	.i_rstn(i_rstn),
	.i_avs_address(i_avs_address),
	.i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_scan_line_switch_output(o_scan_line_switch_output),
	.o_current_sink_output(o_current_sink_output),
	.o_up_deghost_active(o_up_deghost_active),
	.o_up_deghost_level(o_up_deghost_level),
	.o_down_deghost_active(o_down_deghost_active),
	.o_down_deghost_level(o_down_deghost_level),
	.o_sink_comp_level(o_sink_comp_level),
	.o_peak_current_code(o_peak_current_code)
);

// ---- verif/lmscg_led_model.sv ----
// passive led matrix that times the lines and the first three sinks it is driven with
`timescale 1ns/1ps
module lmscg_led_model (
	input wire logic i_core_clk,
	input wire logic [lmscg_pkg::N_LINES-1:0] i_line,
	input wire logic [lmscg_pkg::N_SINKS-1:0] i_sink,
	output logic [15:0] o_slot_cyc,
	output logic [15:0] o_sub_cyc,
	output logic [15:0] o_line_on_cyc,
	output logic [15:0] o_sink_on_cyc,
	output logic [47:0] o_sink_lag,
	output logic [7:0] o_order_err = 8'h0
);
	logic [15:0] cyc_q = 16'h0;
	logic [15:0] sub_q = 16'h0;
	logic [15:0] lon_q = 16'h0;
	logic [15:0] son_q = 16'h0;
	logic [5:0] prev_q = 6'h0;
	logic [5:0] last_q = 6'h0;
	logic [2:0] psink_q = 3'h0;
	logic rise;
	assign rise = |(i_line & ~prev_q);
	always @(posedge i_core_clk) begin
		cyc_q <= cyc_q + 16'h1;
		sub_q <= sub_q + 16'h1;
		lon_q <= lon_q + 16'(|i_line);
		son_q <= son_q + 16'(i_sink[0]);
		prev_q <= i_line;
		psink_q <= i_sink[2:0];
		// a sink lighting in the line's first cycle has no lag at all
		for (int g = 0; g < 3; g++) begin
			if (i_sink[g] && !psink_q[g]) begin
				o_sink_lag[g*16+:16] <= rise ? 16'h0 : cyc_q;
			end
		end
		if (rise) begin
			o_slot_cyc <= cyc_q;
			o_line_on_cyc <= lon_q;
			o_sink_on_cyc <= son_q;
			cyc_q <= 16'h1;
			lon_q <= 16'h1;
			son_q <= 16'(i_sink[0]);
			last_q <= i_line;
			if (i_line != {last_q[4:0], 1'b0} && i_line != 6'h01) begin
				o_order_err <= o_order_err + 8'h1;
			end
		end
		if (i_line[0] && !prev_q[0]) begin
			o_sub_cyc <= sub_q;
			sub_q <= 16'h1;
		end
	end
endmodule : lmscg_led_model

// ---- verif/test_led_matrix_scan_current_gain.sv ----
// self-checking bench for the scan sequencer and current-gain block
`timescale 1ns/1ps
module test_led_matrix_scan_current_gain;
	logic i_core_clk;
	logic i_rstn;
	logic [7:0] i_avs_address;
	logic i_avs_read;
	logic i_avs_write;
	logic [31:0] i_avs_writedata;
	logic [3:0] i_avs_byteenable;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [5:0] o_scan_line_switch_output;
	logic [17:0] o_current_sink_output;
	logic o_up_deghost_active;
	logic [1:0] o_up_deghost_level;
	logic o_down_deghost_active;
	logic [1:0] o_down_deghost_level;
	logic [35:0] o_sink_comp_level;
	logic [2:0] o_peak_current_code;
	logic [15:0] slot_cyc;
	logic [15:0] sub_cyc;
	logic [15:0] line_on_cyc;
	logic [15:0] sink_on_cyc;
	logic [47:0] sink_lag;
	logic [7:0] order_err;
	logic [31:0] rd;
	int bad_count = 0;
	int tests_run = 0;
	longint peak_ua [7] = '{64'h1D4C, 64'h30D4, 64'h61A8, 64'h927C, 64'hC350, 64'h124F8, 64'h186A0};

	lmscg_top dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_scan_line_switch_output(o_scan_line_switch_output),
		.o_current_sink_output(o_current_sink_output), .o_up_deghost_active(o_up_deghost_active),
		.o_up_deghost_level(o_up_deghost_level), .o_down_deghost_active(o_down_deghost_active),
		.o_down_deghost_level(o_down_deghost_level), .o_sink_comp_level(o_sink_comp_level),
		.o_peak_current_code(o_peak_current_code));
	lmscg_led_model matrix (.i_core_clk(i_core_clk), .i_line(o_scan_line_switch_output),
		.i_sink(o_current_sink_output), .o_slot_cyc(slot_cyc), .o_sub_cyc(sub_cyc),
		.o_line_on_cyc(line_on_cyc), .o_sink_on_cyc(sink_on_cyc), .o_sink_lag(sink_lag),
		.o_order_err(order_err));

	function automatic logic [31:0] ua(input longint pk, input longint cc, input longint dc);
		return 32'(pk * cc * dc / (64'h7F * 64'hFF));
	endfunction : ua
	task automatic wrap_up();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// request held until waitrequest is seen low at a rising edge
	task automatic bus_req(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n = 0;
		@(posedge i_core_clk);
		i_avs_address <= addr;
		i_avs_writedata <= data;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (n >= 50) check("bus answer", 64'h1, 64'h0);
	endtask : bus_req
	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		bus_req(1'b0, addr, 32'h0);
		check(what, 64'(rd), 64'(exp));
	endtask : rd_chk
	task automatic scan_chk(input logic [15:0] lines, input logic [15:0] pwm,
		input logic [15:0] blank, input logic [15:0] ph, input logic [15:0] csd);
		logic [15:0] slot;
		slot = pwm + blank + 16'h2 * ph;
		check("slot", 64'(slot_cyc), 64'(slot));
		check("sub period", 64'(sub_cyc), 64'(slot * lines));
		check("line on", 64'(line_on_cyc), 64'(slot - blank));
		check("sink on", 64'(sink_on_cyc), 64'(pwm - csd));
		for (int g = 0; g < 3; g++) begin
			check("sink lag", 64'(sink_lag[g*16+:16]), 64'(16'(g) * ph + csd));
		end
		check("line order", 64'(order_err), 64'h0);
	endtask : scan_chk

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// the whole sequence needs about 32k cycles
	initial begin
		repeat (80000) @(posedge i_core_clk);
		bad_count++;
		wrap_up();
	end
	initial begin
		i_rstn = 1'b0;
		i_avs_address = 8'h0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		repeat (8) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		check("peak out", 64'(o_peak_current_code), 64'h3);
		rd_chk("ctrl", lmscg_pkg::ADDR_CTRL, 32'h502);
		rd_chk("peak", lmscg_pkg::ADDR_PEAK, 32'h303);
		rd_chk("color", lmscg_pkg::ADDR_COLOR, 32'h404040);
		rd_chk("dot", lmscg_pkg::ADDR_DOT_DATA, 32'h80);
		rd_chk("sink ua", lmscg_pkg::ADDR_SINK_UA, ua(64'h927C, 64'h40, 64'h80));
		rd_chk("avg ua", lmscg_pkg::ADDR_AVG_UA, ua(64'h927C, 64'h40, 64'h80) / 32'h6);
		bus_req(1'b1, 8'h30, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h30, 32'h0);
		bus_req(1'b1, lmscg_pkg::ADDR_COLOR, 32'h7F7F7F);
		bus_req(1'b1, lmscg_pkg::ADDR_DOT_DATA, 32'hFF);
		for (int c = 0; c < 7; c++) begin
			bus_req(1'b1, lmscg_pkg::ADDR_PEAK, 32'(c));
			rd_chk("peak now", lmscg_pkg::ADDR_PEAK, 32'(c) * 32'h101);
			rd_chk("sink ua", lmscg_pkg::ADDR_SINK_UA, ua(peak_ua[c], 64'h7F, 64'hFF));
			rd_chk("avg ua", lmscg_pkg::ADDR_AVG_UA, ua(peak_ua[c], 64'h7F, 64'hFF) / 32'h6);
		end
		bus_req(1'b1, lmscg_pkg::ADDR_PEAK, 32'h7);
		rd_chk("peak seven", lmscg_pkg::ADDR_PEAK, 32'h606);
		bus_req(1'b1, lmscg_pkg::ADDR_COLOR, 32'h207F);
		bus_req(1'b1, lmscg_pkg::ADDR_DOT_IDX, 32'h13);
		bus_req(1'b1, lmscg_pkg::ADDR_DOT_IDX, 32'h6C);
		rd_chk("dot index", lmscg_pkg::ADDR_DOT_IDX, 32'h13);
		rd_chk("group sink", lmscg_pkg::ADDR_SINK_UA, ua(64'h186A0, 64'h20, 64'h80));
		// only the low lane may land: first color code changes, the others stay
		i_avs_byteenable <= 4'h1;
		bus_req(1'b1, lmscg_pkg::ADDR_COLOR, 32'h33333311);
		i_avs_byteenable <= 4'hF;
		rd_chk("color lane", lmscg_pkg::ADDR_COLOR, 32'h2011);
		bus_req(1'b1, lmscg_pkg::ADDR_COMP, 32'h030201);
		repeat (2) @(posedge i_core_clk);
		check("comp", 64'(o_sink_comp_level), 64'({6{6'h39}}));
		// frame mode: settings wait for chip enable to rise
		bus_req(1'b1, lmscg_pkg::ADDR_CTRL, 32'h500);
		bus_req(1'b1, lmscg_pkg::ADDR_PEAK, 32'h2);
		bus_req(1'b1, lmscg_pkg::ADDR_DEGHOST, 32'h102);
		rd_chk("peak held", lmscg_pkg::ADDR_PEAK, 32'h602);
		rd_chk("deghost held", lmscg_pkg::ADDR_DEGHOST, 32'h102);
		bus_req(1'b1, lmscg_pkg::ADDR_CTRL, 32'h501);
		// first slot of line zero opens in blank
		rd_chk("status on", lmscg_pkg::ADDR_STATUS, 32'h18);
		rd_chk("peak applied", lmscg_pkg::ADDR_PEAK, 32'h202);
		rd_chk("deghost applied", lmscg_pkg::ADDR_DEGHOST, 32'h1020102);
		bus_req(1'b1, lmscg_pkg::ADDR_PEAK, 32'h4);
		rd_chk("peak refused", lmscg_pkg::ADDR_PEAK, 32'h202);
		check("up level", 64'(o_up_deghost_level), 64'h2);
		check("down level", 64'(o_down_deghost_level), 64'h1);
		repeat (16300) @(posedge i_core_clk);
		scan_chk(16'h6, 16'(lmscg_pkg::CYC_PWM_FAST), 16'(lmscg_pkg::CYC_BLK_LONG), 16'h0, 16'h0);
		bus_req(1'b1, lmscg_pkg::ADDR_CTRL, 32'h27A);
		bus_req(1'b1, lmscg_pkg::ADDR_CTRL, 32'h27B);
		repeat (15300) @(posedge i_core_clk);
		scan_chk(16'h3, 16'(lmscg_pkg::CYC_PWM_SLOW), 16'(lmscg_pkg::CYC_BLK_SHORT),
			16'(lmscg_pkg::CYC_PHASE), 16'(lmscg_pkg::CYC_CSD_SLOW));
		rd_chk("avg three", lmscg_pkg::ADDR_AVG_UA, ua(64'h61A8, 64'h20, 64'h80) / 32'h3);
		i_rstn <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		check("peak again", 64'(o_peak_current_code), 64'h3);
		wrap_up();
	end
endmodule : test_led_matrix_scan_current_gain
